// ---- src/dtid_pkg.sv ----
// constants, types and helpers shared by the data-transfer decoder files
// assumes a single core clock and a 16-entry, 32-bit general register file
//
// What this block does
// - each transfer instruction is accepted in one cycle unless a stall occurs
// - data access waits while an instruction fetch holds the bus
// - next instruction stalls while a pending load targets a register it reads
// - displacement scaled by one, two or four for byte, word, long
// - immediate move sign-extends 8-bit literal into register from bits 11 to 8
// - fetch-pointer loads use scaled displacement; word sign-extends, long unchanged
// - indirect store to address in dest; load from src, sign-extending byte and word
// - pre-decrement store lowers address register by 1, 2 or 4, then writes
// - byte post-increment load sign-extends, then adds 1 to address register
// - word post-increment load sign-extends, then adds 2 to address register
// - long post-increment load reads 32 bits, then adds 4 to address register
// - byte displacement store writes low byte of register zero at base plus disp
// - word displacement store writes low half of register zero at base plus 2*disp
// - long displacement store writes any register at base plus 4*disp
// - byte displacement load sign-extends into register zero
// - word displacement load at base plus 2*disp sign-extends into register zero
// - long displacement load at base plus 4*disp into any register
// - indexed stores write source at register zero plus base, any size
// - indexed byte and word loads sign-extend from register zero plus base
package dtid_pkg;

    localparam int          REG_W      = 32;
    localparam int          REG_CNT    = 16;
    localparam int          IDX_W      = 4;
    localparam logic [31:0] REG_RST    = 32'h0000_0000;
    localparam logic        T_RST      = 1'b0;
    localparam logic [3:0]  R0_IDX     = 4'h0;
    localparam int          MIN_CYCLES = 1;
    localparam logic [31:0] STEP_BYTE  = 32'h0000_0001;
    localparam logic [31:0] STEP_WORD  = 32'h0000_0002;
    localparam logic [31:0] STEP_LONG  = 32'h0000_0004;

    // size codes match the low two bits of the nibble-coded forms
    typedef enum logic [1:0] {
        SZ_BYTE = 2'h0,
        SZ_WORD = 2'h1,
        SZ_LONG = 2'h2
    } dtid_size_t;

    typedef enum logic [2:0] {
        K_NONE, K_IMM, K_MOVE, K_LOAD, K_STORE
    } dtid_kind_t;

    typedef enum logic [2:0] {
        AM_IND, AM_PREDEC, AM_POSTINC, AM_DISP, AM_INDEX, AM_PCREL
    } dtid_mode_t;

    typedef struct packed {
        dtid_kind_t  kind;
        dtid_mode_t  mode;
        dtid_size_t  size;
        logic [3:0]  base_sel;
        logic [3:0]  data_sel;
        logic        uses_base;
        logic        uses_data;
        logic [7:0]  lit;
    } dtid_dec_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] wdata;
        dtid_size_t  size;
        logic        write;
    } dtid_mem_req_t;

    // address step for a given operand size
    function automatic logic [31:0] dtid_step(input dtid_size_t sz);
        case (sz)
            SZ_BYTE: dtid_step = STEP_BYTE;
            SZ_WORD: dtid_step = STEP_WORD;
            default: dtid_step = STEP_LONG;
        endcase
    endfunction : dtid_step

    // zero-extended displacement scaled by operand size
    function automatic logic [31:0] dtid_scale(input logic [7:0] d, input dtid_size_t sz);
        case (sz)
            SZ_BYTE: dtid_scale = {24'h000000, d};
            SZ_WORD: dtid_scale = {23'h000000, d, 1'b0};
            default: dtid_scale = {22'h000000, d, 2'h0};
        endcase
    endfunction : dtid_scale

    // sign extension of a right-aligned value of the given size
    function automatic logic [31:0] dtid_sext(input logic [31:0] v, input dtid_size_t sz);
        case (sz)
            SZ_BYTE: dtid_sext = {{24{v[7]}}, v[7:0]};
            SZ_WORD: dtid_sext = {{16{v[15]}}, v[15:0]};
            default: dtid_sext = v;
        endcase
    endfunction : dtid_sext

    // store data cut to the operand size, upper bits zero
    function automatic logic [31:0] dtid_trim(input logic [31:0] v, input dtid_size_t sz);
        case (sz)
            SZ_BYTE: dtid_trim = {24'h000000, v[7:0]};
            SZ_WORD: dtid_trim = {16'h0000, v[15:0]};
            default: dtid_trim = v;
        endcase
    endfunction : dtid_trim

endpackage : dtid_pkg

// ---- src/dtid_decoder.sv ----
// field decoder for the data-transfer instruction group
// assumes a 16-bit instruction word; purely combinational
`timescale 1ns/1ps
module dtid_decoder (
    // instruction word
    input  wire logic [15:0]       insn_code,
    // decoded fields
    output dtid_pkg::dtid_dec_t    dec
);

    // raw fields
    wire logic [3:0] op   = insn_code[15:12];
    wire logic [3:0] nsel = insn_code[11:8];
    wire logic [3:0] msel = insn_code[7:4];
    wire logic [3:0] lo   = insn_code[3:0];
    wire logic       szok = (lo[1:0] != 2'h3);

    // encoding matches
    wire logic st_ind  = (op == 4'h2) && (lo[3:2] == 2'h0) && szok;
    wire logic st_pre  = (op == 4'h2) && (lo[3:2] == 2'h1) && szok;
    wire logic ld_ind  = (op == 4'h6) && (lo[3:2] == 2'h0) && szok;
    wire logic ld_post = (op == 4'h6) && (lo[3:2] == 2'h1) && szok;
    wire logic mv      = (op == 4'h6) && (lo == 4'h3);
    wire logic st_idx  = (op == 4'h0) && (lo[3:2] == 2'h1) && szok;
    wire logic ld_idx  = (op == 4'h0) && (lo[3:2] == 2'h3) && szok;
    wire logic st_dl   = (op == 4'h1);
    wire logic ld_dl   = (op == 4'h5);
    wire logic st_r0   = (insn_code[15:9] == 7'h40);
    wire logic ld_r0   = (insn_code[15:9] == 7'h42);
    wire logic pc_w    = (op == 4'h9);
    wire logic pc_l    = (op == 4'hd);
    wire logic imm     = (op == 4'he);

    // groups
    wire logic is_st = st_ind | st_pre | st_idx | st_dl | st_r0;
    wire logic is_ld = ld_ind | ld_post | ld_idx | ld_dl | ld_r0 | pc_w | pc_l;
    wire logic r0f   = st_r0 | ld_r0;
    wire logic pcf   = pc_w | pc_l;
    wire logic dispf = st_dl | ld_dl | r0f;

    assign dec.kind = imm   ? dtid_pkg::K_IMM   :
                      mv    ? dtid_pkg::K_MOVE  :
                      is_ld ? dtid_pkg::K_LOAD  :
                      is_st ? dtid_pkg::K_STORE : dtid_pkg::K_NONE;
    assign dec.mode = st_pre  ? dtid_pkg::AM_PREDEC  :
                      ld_post ? dtid_pkg::AM_POSTINC :
                      dispf   ? dtid_pkg::AM_DISP    :
                      (st_idx | ld_idx) ? dtid_pkg::AM_INDEX :
                      pcf     ? dtid_pkg::AM_PCREL   : dtid_pkg::AM_IND;
    // size from bit 8, fixed long, fixed word, or the low nibble
    assign dec.size = r0f ? (insn_code[8] ? dtid_pkg::SZ_WORD : dtid_pkg::SZ_BYTE) :
                      (st_dl | ld_dl | pc_l) ? dtid_pkg::SZ_LONG :
                      pc_w ? dtid_pkg::SZ_WORD : dtid_pkg::dtid_size_t'(lo[1:0]);
    // stores address through bits 11:8, loads, moves and register-zero stores through bits 7:4
    assign dec.base_sel  = (is_st && !st_r0) ? nsel : msel;
    assign dec.data_sel  = r0f ? dtid_pkg::R0_IDX : (is_st ? msel : nsel);
    assign dec.uses_base = !(imm | pcf) && (is_st | is_ld | mv);
    assign dec.uses_data = is_st;
    assign dec.lit       = (imm | pcf) ? insn_code[7:0] : {4'h0, lo};

endmodule : dtid_decoder

// ---- src/dtid_regfile.sv ----
// general register file, sixteen 32-bit entries
// assumes port b carries an older result than port a in the same cycle
`timescale 1ns/1ps
module dtid_regfile (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        reset_n,
    // read ports
    input  wire logic [3:0]  rd_a_sel,
    output logic [31:0]      rd_a_data,
    input  wire logic [3:0]  rd_b_sel,
    output logic [31:0]      rd_b_data,
    output logic [31:0]      rd_r0_data,
    input  wire logic [3:0]  rd_d_sel,
    output logic [31:0]      rd_d_data,
    // write ports, a wins over b
    input  wire logic        wa_en,
    input  wire logic [3:0]  wa_sel,
    input  wire logic [31:0] wa_data,
    input  wire logic        wb_en,
    input  wire logic [3:0]  wb_sel,
    input  wire logic [31:0] wb_data
);

    logic [31:0] regs [dtid_pkg::REG_CNT];

    // reads straight from the array
    assign rd_a_data  = regs[rd_a_sel];
    assign rd_b_data  = regs[rd_b_sel];
    assign rd_r0_data = regs[dtid_pkg::R0_IDX];
    assign rd_d_data  = regs[rd_d_sel];

    // older load result first, newer execute result overrides
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            for (int i = 0; i < dtid_pkg::REG_CNT; i++) begin
                regs[i] <= dtid_pkg::REG_RST;
            end
        end else begin
            if (wb_en) regs[wb_sel] <= wb_data;
            if (wa_en) regs[wa_sel] <= wa_data;
        end
    end

endmodule : dtid_regfile

// ---- src/dtid_core.sv ----
// execute logic for the data-transfer instruction group
// two stages: execute (registers, address, register updates) and memory
// assumes the fetch stage holds insn_code stable until insn_ready
// assumes the data port returns read data in the cycle it raises mem_ready
`timescale 1ns/1ps
module dtid_core (
    // clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  reset_n,
    // instruction from fetch
    input  wire logic                  insn_valid,
    input  wire logic [15:0]           insn_code,
    input  wire logic [31:0]           insn_fetch_ptr,
    output logic                       insn_ready,
    // bus contention from the fetch unit
    input  wire logic                  fetch_busy,
    // data memory port
    output logic                       mem_valid,
    output dtid_pkg::dtid_mem_req_t    mem_req,
    input  wire logic                  mem_ready,
    input  wire logic [31:0]           mem_rdata,
    // execution status
    output logic                       insn_retired,
    output logic                       insn_unknown,
    // condition flag, owned by other instruction groups
    input  wire logic                  t_flag_load,
    input  wire logic                  t_flag_value,
    output logic                       t_flag,
    // register observation
    input  wire logic [3:0]            dbg_sel,
    output logic [31:0]                dbg_data
);

    // decoded instruction
    dtid_pkg::dtid_dec_t dec;

    // register file read values
    logic [31:0] base_val;
    logic [31:0] data_val;
    logic [31:0] r0_val;

    // memory stage state
    logic                    m_valid_r;
    logic                    m_valid_nxt;
    dtid_pkg::dtid_mem_req_t m_req_r;
    dtid_pkg::dtid_mem_req_t m_req_nxt;
    logic [3:0]              m_dest_r;
    logic [3:0]              m_dest_nxt;

    // status and flag registers
    logic insn_retired_r;
    logic insn_unknown_r;
    logic t_flag_r;
    logic t_flag_nxt;

    // field decode
    dtid_decoder u_decoder (
        .insn_code (insn_code),
        .dec       (dec)
    );

    // instruction classes
    wire logic is_imm   = (dec.kind == dtid_pkg::K_IMM);
    wire logic is_move  = (dec.kind == dtid_pkg::K_MOVE);
    wire logic is_load  = (dec.kind == dtid_pkg::K_LOAD);
    wire logic is_store = (dec.kind == dtid_pkg::K_STORE);
    wire logic is_mem   = is_load | is_store;
    wire logic is_none  = (dec.kind == dtid_pkg::K_NONE);
    wire logic is_pre   = (dec.mode == dtid_pkg::AM_PREDEC);
    wire logic is_post  = (dec.mode == dtid_pkg::AM_POSTINC);
    wire logic is_index = (dec.mode == dtid_pkg::AM_INDEX);

    // memory stage handshake; fetch owns the bus first
    wire logic m_load = m_valid_r && !m_req_r.write;
    assign mem_valid = m_valid_r && !fetch_busy;
    wire logic m_done = mem_valid && mem_ready;
    wire logic m_busy = m_valid_r && !m_done;

    // load-use: the pending load writes at its done edge, so any read waits
    wire logic hz_base  = dec.uses_base && (dec.base_sel == m_dest_r);
    wire logic hz_data  = dec.uses_data && (dec.data_sel == m_dest_r);
    wire logic hz_r0    = is_index && (m_dest_r == dtid_pkg::R0_IDX);
    wire logic hazard   = m_load && (hz_base || hz_data || hz_r0);

    // accept in one cycle when nothing blocks
    assign insn_ready = !m_busy && !hazard;
    wire logic x_fire = insn_valid && insn_ready;

    // operand sizing
    wire logic [31:0] step   = dtid_pkg::dtid_step(dec.size);
    wire logic [31:0] scaled = dtid_pkg::dtid_scale(dec.lit, dec.size);

    // effective address by mode
    wire logic [31:0] ea_ind  = base_val;
    wire logic [31:0] ea_pre  = base_val - step;
    wire logic [31:0] ea_disp = base_val + scaled;
    wire logic [31:0] ea_idx  = base_val + r0_val;
    wire logic [31:0] ea_pc   = insn_fetch_ptr + scaled;

    logic [31:0] ea;
    always_comb begin
        case (dec.mode)
            dtid_pkg::AM_PREDEC:  ea = ea_pre;
            dtid_pkg::AM_DISP:    ea = ea_disp;
            dtid_pkg::AM_INDEX:   ea = ea_idx;
            dtid_pkg::AM_PCREL:   ea = ea_pc;
            default:              ea = ea_ind;
        endcase
    end

    // immediate literal widened with its sign
    wire logic [31:0] imm_val = dtid_pkg::dtid_sext({24'h000000, dec.lit},
                                                    dtid_pkg::SZ_BYTE);

    // post-increment address after the access
    wire logic [31:0] post_val = base_val + step;

    // execute-stage register write: result, or updated address register
    wire logic        wa_en  = x_fire && (is_imm || is_move || is_pre || is_post);
    wire logic [3:0]  wa_sel = (is_imm || is_move) ? dec.data_sel : dec.base_sel;
    wire logic [31:0] wa_data = is_imm  ? imm_val  :
                                is_move ? base_val :
                                is_pre  ? ea_pre   : post_val;

    // load return: sized and sign-extended into the destination
    wire logic        wb_en   = m_done && m_load;
    wire logic [31:0] wb_data = dtid_pkg::dtid_sext(mem_rdata, m_req_r.size);

    // store data: source register cut to the access size
    wire logic [31:0] st_data = dtid_pkg::dtid_trim(data_val, dec.size);

    // register file
    dtid_regfile u_regfile (
        .clk_sys    (clk_sys),
        .reset_n    (reset_n),
        .rd_a_sel   (dec.base_sel),
        .rd_a_data  (base_val),
        .rd_b_sel   (dec.data_sel),
        .rd_b_data  (data_val),
        .rd_r0_data (r0_val),
        .rd_d_sel   (dbg_sel),
        .rd_d_data  (dbg_data),
        .wa_en      (wa_en),
        .wa_sel     (wa_sel),
        .wa_data    (wa_data),
        .wb_en      (wb_en),
        .wb_sel     (m_dest_r),
        .wb_data    (wb_data)
    );

    // next memory-stage request
    always_comb begin
        m_valid_nxt = m_valid_r;
        m_req_nxt   = m_req_r;
        m_dest_nxt  = m_dest_r;
        if (m_done) begin
            m_valid_nxt = 1'b0;
        end
        if (x_fire && is_mem) begin
            m_valid_nxt     = 1'b1;
            m_req_nxt.addr  = ea;
            m_req_nxt.wdata = is_store ? st_data : 32'h0000_0000;
            m_req_nxt.size  = dec.size;
            m_req_nxt.write = is_store;
            m_dest_nxt      = dec.data_sel;
        end
    end

    // memory-stage registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            m_valid_r <= 1'b0;
            m_req_r   <= '0;
            m_dest_r  <= dtid_pkg::R0_IDX;
        end else begin
            m_valid_r <= m_valid_nxt;
            m_req_r   <= m_req_nxt;
            m_dest_r  <= m_dest_nxt;
        end
    end

    assign mem_req = m_req_r;

    // flag changes only through its owner, never by a transfer
    assign t_flag_nxt = t_flag_load ? t_flag_value : t_flag_r;

    // status pulses and flag
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            insn_retired_r <= 1'b0;
            insn_unknown_r <= 1'b0;
            t_flag_r       <= dtid_pkg::T_RST;
        end else begin
            insn_retired_r <= x_fire;
            insn_unknown_r <= x_fire && is_none;
            t_flag_r       <= t_flag_nxt;
        end
    end

    assign insn_retired = insn_retired_r;
    assign insn_unknown = insn_unknown_r;
    assign t_flag       = t_flag_r;

endmodule : dtid_core

// ---- testbench/dtid_core_chk.sv ----
// port checks for the data-transfer core
// assumes one clock, async active-low reset; bound below
`timescale 1ns/1ps
module dtid_core_chk (
    // clock and reset
    input logic                    clk_sys,
    input logic                    reset_n,
    // instruction port
    input logic                    insn_valid,
    input logic [15:0]             insn_code,
    input logic [31:0]             insn_fetch_ptr,
    input logic                    insn_ready,
    input logic                    insn_retired,
    // data port
    input logic                    fetch_busy,
    input logic                    mem_valid,
    input dtid_pkg::dtid_mem_req_t mem_req,
    input logic                    mem_ready,
    // flag and observation
    input logic                    t_flag_load,
    input logic                    t_flag_value,
    input logic                    t_flag,
    input logic [3:0]              dbg_sel,
    input logic [31:0]             dbg_data
);
    // take strobe and fetch-pointer forms
    wire logic take  = insn_valid && insn_ready;
    wire logic pcrel = insn_code[15:12] inside {4'h9, 4'hd};

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    a_take_retires: assert property (take |=> insn_retired)
        else $error("no retire");
    a_no_spurious: assert property (insn_retired |-> $past(take))
        else $error("stray retire");
    a_fetch_blocks: assert property (fetch_busy |-> !mem_valid)
        else $error("request under fetch");
    a_req_holds: assert property (mem_valid && !mem_ready |=> $stable(mem_req))
        else $error("request moved");
    a_busy_stalls: assert property (mem_valid && !mem_ready |-> !insn_ready)
        else $error("taken while waiting");
    a_imm_sext: assert property (take && insn_code[15:12] == 4'he &&
        dbg_sel == insn_code[11:8] |=> dbg_sel != $past(dbg_sel) ||
        dbg_data == {{24{$past(insn_code[7])}}, $past(insn_code[7:0])})
        else $error("imm result");
    a_pcrel_addr: assert property (take && pcrel |=> mem_req.addr ==
        $past(insn_fetch_ptr) + ($past(insn_code[14]) ? {22'h0, $past(insn_code[7:0]), 2'h0}
        : {23'h0, $past(insn_code[7:0]), 1'b0}) && mem_req.size ==
        ($past(insn_code[14]) ? dtid_pkg::SZ_LONG : dtid_pkg::SZ_WORD))
        else $error("pcrel address");
    a_byte_trim: assert property (mem_valid && mem_req.write &&
        mem_req.size == dtid_pkg::SZ_BYTE |-> mem_req.wdata[31:8] == 24'h0)
        else $error("byte wdata");
    a_flag_hold: assert property (!t_flag_load |=> $stable(t_flag))
        else $error("flag changed");
    a_flag_load: assert property (t_flag_load |=> t_flag == $past(t_flag_value))
        else $error("flag load");
endmodule : dtid_core_chk

bind dtid_core dtid_core_chk u_chk (
    .clk_sys(clk_sys), .reset_n(reset_n), .insn_valid(insn_valid), .insn_code(insn_code),
    .insn_fetch_ptr(insn_fetch_ptr), .insn_ready(insn_ready), .insn_retired(insn_retired),
    .fetch_busy(fetch_busy), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
    .t_flag_load(t_flag_load), .t_flag_value(t_flag_value), .t_flag(t_flag),
    .dbg_sel(dbg_sel), .dbg_data(dbg_data)
);

// ---- testbench/dtid_mem_model.sv ----
// data memory responder, prompt or with random waits
// assumes requests settle by 2 ns after the edge
`timescale 1ns/1ps
module dtid_mem_model (
    // clock
    input logic                    clk_sys,
    // request side
    input logic                    mem_valid,
    input dtid_pkg::dtid_mem_req_t mem_req,
    // answer side
    output logic                   mem_ready,
    output logic [31:0]            mem_rdata,
    // high for random wait states
    input logic                    slow
);
    // idle answer lines
    initial begin
        mem_ready = 1'b0;
        mem_rdata = 32'h0;
    end

    // data from the address; toggles when idle
    always @(posedge clk_sys) begin
        #2;
        mem_ready = !slow || ($urandom % 3 == 0);
        if (mem_ready && mem_valid) begin
            mem_rdata = {mem_req.addr[15:0], mem_req.addr[31:16]} ^ 32'hc3a5_5a3c;
        end else begin
            mem_rdata = ~mem_rdata;
        end
    end
endmodule : dtid_mem_model

// ---- testbench/testbench.sv ----
// self-checking bench for the data-transfer core
// assumes package, design and checker compiled first
`timescale 1ns/1ps
module testbench;
    logic                    clk_sys = 1'b0, reset_n = 1'b0, insn_valid = 1'b0, slow = 1'b0;
    logic                    fetch_busy = 1'b0, t_flag_load = 1'b0, t_flag_value = 1'b0;
    logic                    busy_on = 1'b0;
    logic [15:0]             insn_code = 16'h0;
    logic [31:0]             insn_fetch_ptr = 32'h0;
    logic [3:0]              dbg_sel = 4'h0;
    logic                    insn_ready, mem_valid, mem_ready, insn_retired, insn_unknown, t_flag;
    logic [31:0]             mem_rdata, dbg_data;
    dtid_pkg::dtid_mem_req_t mem_req;
    logic [31:0]             rf [16];
    dtid_pkg::dtid_mem_req_t memq [$];
    logic [31:0]             regq [$];
    int                      mismatches = 0, n_checks = 0, cyc = 0;
    int                      took;
    event                    look;

    dtid_core dut (
        .clk_sys(clk_sys), .reset_n(reset_n), .insn_valid(insn_valid), .insn_code(insn_code),
        .insn_fetch_ptr(insn_fetch_ptr), .insn_ready(insn_ready), .fetch_busy(fetch_busy),
        .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready), .mem_rdata(mem_rdata),
        .insn_retired(insn_retired), .insn_unknown(insn_unknown), .t_flag_load(t_flag_load),
        .t_flag_value(t_flag_value), .t_flag(t_flag), .dbg_sel(dbg_sel), .dbg_data(dbg_data)
    );
    dtid_mem_model u_mem (
        .clk_sys(clk_sys), .mem_valid(mem_valid), .mem_req(mem_req), .mem_ready(mem_ready),
        .mem_rdata(mem_rdata), .slow(slow)
    );

    // 25 MHz core clock
    always #20 clk_sys = ~clk_sys;

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : final_report

    task automatic cmp_mem(input dtid_pkg::dtid_mem_req_t e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error mem_req expected %h seen %h", e, g);
        end
    endtask : cmp_mem

    task automatic cmp_val(input string what, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : cmp_val

    function automatic logic [31:0] sx(input logic [31:0] v, input logic [1:0] sz);
        sx = sz == 2'h0 ? {{24{v[7]}}, v[7:0]} : (sz == 2'h1 ? {{16{v[15]}}, v[15:0]} : v);
    endfunction : sx

    // queues one expected access, store data cut to its size
    task automatic note(input logic [31:0] a, wd, input logic [1:0] sz, input logic w);
        memq.push_back('{addr: a, wdata: wd & ~(32'hffff_ffff << (8 << sz)),
                         size: dtid_pkg::dtid_size_t'(sz), write: w});
    endtask : note

    // offers an instruction until taken
    task automatic issue(input logic [15:0] code, input logic [31:0] fp);
        insn_valid = 1'b1;
        insn_code = code;
        insn_fetch_ptr = fp;
        t_flag_value = 1'($urandom);
        took = 0;
        do begin
            @(negedge clk_sys);
            took++;
        end while (insn_ready !== 1'b1 && took < 100);
        @(posedge clk_sys);
        #1;
    endtask : issue

    // drains accesses, then n cycles
    task automatic idle(input int n);
        insn_valid = 1'b0;
        for (int i = 0; i < 200 && memq.size() > 0; i++) begin
            @(posedge clk_sys);
            #1;
        end
        repeat (n) begin
            @(posedge clk_sys);
            #1;
        end
    endtask : idle

    // queues a register check
    task automatic chk_reg(input logic [3:0] r, input logic [31:0] e);
        dbg_sel = r;
        regq.push_back(e);
        @(negedge clk_sys);
        -> look;
        @(posedge clk_sys);
        #1;
    endtask : chk_reg

    // oldest note against each done access
    always @(negedge clk_sys) begin
        if (mem_valid === 1'b1 && mem_ready === 1'b1) begin
            cmp_mem(memq.size() > 0 ? memq.pop_front() : '1, mem_req);
        end
    end
    always @(look) cmp_val("register", regq.pop_front(), dbg_data);

    // random fetch contention
    always @(posedge clk_sys) begin
        #1;
        fetch_busy = busy_on && ($urandom % 4 == 0);
    end

    // hang guard
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            final_report();
        end
    end

    initial begin
        logic [3:0]  n, m, dn;
        logic [7:0]  d8;
        logic [31:0] a, fp;
        logic [1:0]  sz;
        logic [15:0] code;
        void'($urandom(68));
        repeat (3) @(posedge clk_sys);
        #1;
        reset_n = 1'b1;
        t_flag_load = 1'b1;
        t_flag_value = 1'b1;
        @(posedge clk_sys);
        #1;
        t_flag_load = 1'b0;
        // immediates back to back, then a move
        for (int r = 0; r < 16; r++) begin
            d8 = 8'($urandom);
            rf[r] = {{24{d8[7]}}, d8};
            dbg_sel = 4'(r);
            issue({4'he, 4'(r), d8}, 32'h0);
            cmp_val("cycles", 32'h1, 32'(took));
        end
        issue(16'h6f33, 32'h0);
        rf[15] = rf[3];
        issue(16'h3000, 32'h0);
        cmp_val("insn_unknown", 32'h1, {31'h0, insn_unknown});
        idle(2);
        for (int r = 0; r < 16; r++) chk_reg(4'(r), rf[r]);
        $display("test imm_and_move done");
        // all stores, waits and contention
        slow = 1'b1;
        busy_on = 1'b1;
        for (int k = 0; k < 12; k++) begin
            n = 4'(1 + $urandom % 13);
            m = n % 4'hd + 4'h1;
            d8 = 8'($urandom);
            sz = 2'(k % 3);
            case (k / 3)
                0: begin
                    code = {4'h2, n, m, 2'h0, sz};
                    a = rf[n];
                end
                1: begin
                    code = {4'h2, n, m, 2'h1, sz};
                    rf[n] = rf[n] - (32'h1 << sz);
                    a = rf[n];
                end
                2: begin
                    code = sz == 2'h2 ? {4'h1, n, m, d8[3:0]} : {7'h40, sz[0], n, d8[3:0]};
                    a = rf[n] + ({28'h0, d8[3:0]} << sz);
                end
                default: begin
                    code = {4'h0, n, m, 2'h1, sz};
                    a = rf[0] + rf[n];
                end
            endcase
            note(a, (k / 3 == 2 && sz != 2'h2) ? rf[0] : rf[m], sz, 1'b1);
            issue(code, 32'h0);
        end
        idle(2);
        for (int r = 0; r < 16; r++) chk_reg(4'(r), rf[r]);
        $display("test stores done");
        // all loads except indexed long, each then read
        for (int k = 0; k < 13; k++) begin
            n = 4'(1 + $urandom % 13);
            m = n % 4'hd + 4'h1;
            d8 = 8'($urandom);
            fp = $urandom;
            slow = k[0];
            sz = 2'(k < 9 ? k % 3 : (k < 11 ? k - 9 : k - 10));
            dn = (k == 6 || k == 7) ? 4'h0 : n;
            case (k)
                0, 1, 2: begin
                    code = {4'h6, n, m, 2'h0, sz};
                    a = rf[m];
                end
                3, 4, 5: begin
                    code = {4'h6, n, m, 2'h1, sz};
                    a = rf[m];
                    rf[m] = rf[m] + (32'h1 << sz);
                end
                6, 7, 8: begin
                    code = sz == 2'h2 ? {4'h5, n, m, d8[3:0]} : {7'h42, sz[0], m, d8[3:0]};
                    a = rf[m] + ({28'h0, d8[3:0]} << sz);
                end
                9, 10: begin
                    code = {4'h0, n, m, 2'h3, sz};
                    a = rf[0] + rf[m];
                end
                default: begin
                    code = {sz == 2'h1 ? 4'h9 : 4'hd, n, d8};
                    a = fp + ({24'h0, d8} << sz);
                end
            endcase
            note(a, 32'h0, sz, 1'b0);
            issue(code, fp);
            rf[dn] = sx({a[15:0], a[31:16]} ^ 32'hc3a5_5a3c, sz);
            issue({8'h6e, dn, 4'h3}, 32'h0);
            rf[14] = rf[dn];
            idle(2);
            chk_reg(dn, rf[dn]);
            chk_reg(4'he, rf[14]);
            chk_reg(m, rf[m]);
        end
        $display("test loads done");
        cmp_val("t_flag", 32'h1, {31'h0, t_flag});
        final_report();
    end
endmodule : testbench
